// ===== src/emrb_pkg.sv
package emrb_pkg;

  // ************************************************************
  // sizes and address map
  // ************************************************************
  localparam int unsigned NPORT = 8;
  localparam int unsigned AW    = 16;
  localparam int unsigned DW    = 32;

  localparam logic [15:0] HDR_OFS      = 16'h1000;
  localparam logic [15:0] IRQ_STAT_OFS = 16'h1010;
  localparam logic [15:0] IRQ_EN_OFS   = 16'h1014;
  localparam logic [15:0] IRQ_CLR_OFS  = 16'h1018;
  localparam logic [15:0] PWID_OFS     = 16'h1028;
  localparam logic [15:0] WIN_BASE     = 16'h1040;
  localparam logic [15:0] WIN_END      = 16'h123F;
  localparam logic [5:0]  DET_OFS      = 6'h00;
  localparam logic [5:0]  CAP_OFS      = 6'h08;

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  localparam logic [15:0] NEXT_PTR_VAL = 16'h0000;
  localparam logic [15:0] FEAT_ID_VAL  = 16'h0007;
  localparam logic [31:0] HDR_VAL      = {NEXT_PTR_VAL, FEAT_ID_VAL};
  localparam int unsigned HIGH_LSB     = 24;
  localparam int unsigned LOW_LSB      = 16;
  localparam int unsigned WIDE_POS     = 15;
  localparam int unsigned FLAG_POS     = 31;
  localparam logic [31:0] PWID_RST     = 32'h0000_0000;
  localparam logic [31:0] PWID_WMASK   = 32'hFFFF_8000;
  localparam logic [31:0] CAP_RST      = 32'h0000_0000;
  localparam logic [7:0]  IEN_RST      = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef logic [DW-1:0] emrb_word_t;

  typedef enum logic [0:0] {
    EMRB_BOOT = 1'b0,
    EMRB_RUN  = 1'b1
  } emrb_phase_e;

  typedef struct packed {
    logic [15:0] dest_id;
    logic        wide;
  } emrb_pw_dest_s;

  typedef struct packed {
    logic [NPORT-1:0] s1;
    logic [NPORT-1:0] s2;
  } emrb_sync_s;

  typedef struct packed {
    emrb_phase_e                  phase;
    emrb_word_t                   pwid;
    logic [NPORT-1:0]             flag;
    emrb_word_t [NPORT-1:0]       cap;
    logic [NPORT-1:0]             ist;
    logic [NPORT-1:0]             ien;
    emrb_word_t                   rdata;
    emrb_pw_dest_s                pw;
  } emrb_state_s;

  localparam emrb_state_s EMRB_STATE_RST = '0;

  // ************************************************************
  // address decode helpers
  // ************************************************************
  function automatic logic emrb_in_win(input logic [15:0] a);
    return (a >= WIN_BASE) && (a <= WIN_END);
  endfunction

  function automatic logic [2:0] emrb_port_of(input logic [15:0] a);
    logic [15:0] rel;
    rel = a - WIN_BASE;
    return rel[8:6];
  endfunction

endpackage

// ===== src/emrb_sync2.sv
`timescale 1ns/1ps
module emrb_sync2
  import emrb_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [NPORT-1:0] din,
  output logic      [NPORT-1:0] dout
);

  emrb_sync_s sync_reg;
  emrb_sync_s sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg.s2;

endmodule // emrb_sync2

// ===== src/emrb_pw_fmt.sv
`timescale 1ns/1ps
module emrb_pw_fmt
  import emrb_pkg::*;
(
  input  wire emrb_word_t    pwid,
  output emrb_pw_dest_s      dest
);

  always_comb begin
    dest.wide = pwid[WIDE_POS];
    if (pwid[WIDE_POS]) begin
      dest.dest_id = {pwid[HIGH_LSB +: 8], pwid[LOW_LSB +: 8]};
    end else begin
      dest.dest_id = {8'h00, pwid[LOW_LSB +: 8]};
    end
  end

endmodule // emrb_pw_fmt

// ===== src/emrb_regs.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module emrb_regs
  import emrb_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  // register port
  input  wire logic [AW-1:0]          reg_addr,
  input  wire logic [DW-1:0]          reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [DW-1:0]          reg_rdata,
  // boot loader port
  input  wire logic                   load_wr,
  input  wire logic [AW-1:0]          load_addr,
  input  wire logic [DW-1:0]          load_wdata,
  input  wire logic                   load_done,
  // device control
  input  wire logic                   self_reset,
  input  wire logic [NPORT-1:0]       port_power_down,
  // per-port logical/transport error events
  input  wire logic [NPORT-1:0]       lt_err_evt,
  input  wire emrb_word_t [NPORT-1:0] lt_err_info,
  // outputs
  output emrb_pw_dest_s               pw_dest,
  output logic      [NPORT-1:0]       logical_transport_error_flag,
  output logic                        boot_active,
  output logic                        irq
);

  // ************************************************************
  // state
  // ************************************************************
  emrb_state_s           st_reg;
  emrb_state_s           st_next;

  logic [NPORT-1:0]      pdown;
  emrb_pw_dest_s         fmt_dest;

  // ************************************************************
  // power-down pins cross in from outside
  // ************************************************************
  emrb_sync2 u_pdown_sync (
    .mclk (mclk),
    .rstn (rstn),
    .din  (port_power_down),
    .dout (pdown)
  );

  // ************************************************************
  // port-write destination formatting
  // ************************************************************
  emrb_pw_fmt u_pw_fmt (
    .pwid (st_reg.pwid),
    .dest (fmt_dest)
  );

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    logic             wr;
    logic [AW-1:0]    waddr;
    logic [DW-1:0]    wdata;
    logic             rd_win;
    logic             wr_win;
    logic [2:0]       rport;
    logic [2:0]       wport;
    logic [5:0]       roff;
    logic [5:0]       woff;
    emrb_word_t       rval;

    wr     = 1'b0;
    waddr  = '0;
    wdata  = '0;
    rd_win = 1'b0;
    wr_win = 1'b0;
    rport  = '0;
    wport  = '0;
    roff   = '0;
    woff   = '0;
    rval   = '0;
    st_next = st_reg;

    // -------- write source select --------
    // loader writes in boot
    if ((st_reg.phase == EMRB_BOOT) && load_wr) begin
      wr    = 1'b1;
      waddr = load_addr;
      wdata = load_wdata;
    end else if (reg_wr) begin
      wr    = 1'b1;
      waddr = reg_addr;
      wdata = reg_wdata;
    end

    // -------- boot phase --------
    case (st_reg.phase)
      EMRB_BOOT: begin
        if (load_done) begin
          st_next.phase = EMRB_RUN;
        end
      end
      EMRB_RUN: begin
        st_next.phase = EMRB_RUN;
      end
      default: begin
        st_next.phase = EMRB_BOOT;
      end
    endcase

    // -------- port window decode --------
    // window decode
    rd_win = emrb_in_win(reg_addr);
    rport  = emrb_port_of(reg_addr);
    roff   = reg_addr[5:0];
    wr_win = emrb_in_win(waddr);
    wport  = emrb_port_of(waddr);
    woff   = waddr[5:0];

    // -------- read path --------
    // zero by default
    rval = '0;
    if (reg_rd) begin
      if (reg_addr[1:0] != 2'b00) begin
        rval = '0;
      end else if (reg_addr == HDR_OFS) begin
        rval = HDR_VAL;
      end else if (reg_addr == PWID_OFS) begin
        rval = st_reg.pwid;
      end else if (reg_addr == IRQ_STAT_OFS) begin
        rval = {24'h000000, st_reg.ist};
      end else if (reg_addr == IRQ_EN_OFS) begin
        rval = {24'h000000, st_reg.ien};
      end else if (rd_win) begin
        if (pdown[rport]) begin
          rval = '0;
        end else if (roff == DET_OFS) begin
          rval = '0;
          rval[FLAG_POS] = st_reg.flag[rport];
        end else if (roff == CAP_OFS) begin
          rval = st_reg.cap[rport];
        end else begin
          rval = '0;
        end
      end
    end
    st_next.rdata = rval;

    // -------- write path --------
    // unmatched writes dropped
    if (wr && (waddr[1:0] == 2'b00)) begin
      if (waddr == PWID_OFS) begin
        st_next.pwid = wdata & PWID_WMASK;
      end else if (waddr == IRQ_EN_OFS) begin
        st_next.ien = wdata[NPORT-1:0];
      end else if (waddr == IRQ_CLR_OFS) begin
        st_next.ist = st_reg.ist & ~wdata[NPORT-1:0];
      end else if (wr_win && !pdown[wport]) begin
        // writing zero clears the flag; capture is read-only
        if ((woff == DET_OFS) && !wdata[FLAG_POS]) begin
          st_next.flag[wport] = 1'b0;
        end
      end
    end

    // -------- error events --------
    // events land after the clears so a same-cycle set wins
    for (int i = 0; i < NPORT; i++) begin
      if (lt_err_evt[i] && !pdown[i]) begin
        if (!st_reg.flag[i]) begin
          st_next.cap[i] = lt_err_info[i];
        end
        st_next.flag[i] = 1'b1;
        st_next.ist[i]  = 1'b1;
      end
    end

    // -------- port power cycle --------
    // powered-down port's flag and capture held at reset; its interrupt status bit keeps its value
    for (int i = 0; i < NPORT; i++) begin
      if (pdown[i]) begin
        st_next.flag[i] = 1'b0;
        st_next.cap[i]  = CAP_RST;
      end
    end

    // -------- port-write destination --------
    // destination from target ID
    st_next.pw = fmt_dest;

    // -------- device self-reset --------
    // self-reset restores all
    if (self_reset) begin
      st_next       = EMRB_STATE_RST;
      st_next.pwid  = PWID_RST;
      st_next.ien   = IEN_RST;
      st_next.phase = EMRB_BOOT;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= EMRB_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // port disable has no input here: nothing it does may clear state
  // values retained
  assign reg_rdata = st_reg.rdata;

  // routing of the packet itself is left to the switch lookup
  // destination to router
  assign pw_dest = st_reg.pw;

  assign logical_transport_error_flag = st_reg.flag;
  assign boot_active = (st_reg.phase == EMRB_BOOT);
  assign irq = |(st_reg.ist & st_reg.ien);

endmodule // emrb_regs

// ===== dv/emrb_regs_chk.sv
`timescale 1ns/1ps
module emrb_regs_chk
  import emrb_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rstn,
  input wire logic [AW-1:0]    reg_addr,
  input wire logic [DW-1:0]    reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [DW-1:0]    reg_rdata,
  input wire logic             load_wr,
  input wire logic             load_done,
  input wire logic             self_reset,
  input wire logic [NPORT-1:0] port_power_down,
  input wire logic [NPORT-1:0] lt_err_evt,
  input wire emrb_pw_dest_s    pw_dest,
  input wire logic [NPORT-1:0] logical_transport_error_flag,
  input wire logic             boot_active,
  input wire logic             irq
);
  // ****************
  // assertions
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside a read");
  AST_HDR: assert property (reg_rd && reg_addr == HDR_OFS && !self_reset |=>
    reg_rdata == HDR_VAL) else $error("header read wrong");
  AST_UNALIGNED: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == '0)
    else $error("unaligned read not zero");
  // window held at zero only once the power-down pins have settled
  AST_PD_READ: assert property (reg_rd && reg_addr >= WIN_BASE && reg_addr <= WIN_END
    && port_power_down == '1 && $past(port_power_down, 2) == '1
    && $past(port_power_down, 3) == '1 |=> reg_rdata == '0)
    else $error("powered-down window read not zero");
  AST_PW_DEST: assert property (reg_wr && reg_addr == PWID_OFS && !load_wr && !self_reset
    ##1 !reg_wr && !load_wr && !self_reset |=> pw_dest.wide == $past(reg_wdata[15], 2) &&
    pw_dest.dest_id == ($past(reg_wdata[15], 2) ? $past(reg_wdata[31:16], 2) :
    {8'h00, $past(reg_wdata[23:16], 2)})) else $error("port-write target wrong");
  AST_EVT: assert property (lt_err_evt != '0 && port_power_down == '0 && !self_reset &&
    $past(port_power_down, 2) == '0 && $past(port_power_down, 3) == '0 |=>
    (logical_transport_error_flag & $past(lt_err_evt)) == $past(lt_err_evt))
    else $error("error event not flagged");
  AST_FLAG_CAUSE: assert property ((logical_transport_error_flag &
    ~$past(logical_transport_error_flag) & ~$past(lt_err_evt)) == '0)
    else $error("flag set without event");
  AST_SELF_RST: assert property (self_reset |=> boot_active && pw_dest == '0 &&
    logical_transport_error_flag == '0) else $error("self reset incomplete");
  AST_BOOT_END: assert property (load_done && boot_active && !self_reset |=> !boot_active)
    else $error("boot phase did not end");
  AST_BOOT_RISE: assert property ($rose(boot_active) |-> $past(self_reset))
    else $error("boot phase restarted without self reset");
  COV_IRQ: cover property (irq);
  COV_PD_RD: cover property (reg_rd && port_power_down == '1);
  COV_BOOT: cover property (load_done && boot_active);
endmodule // emrb_regs_chk

bind emrb_regs emrb_regs_chk i_emrb_regs_chk (
  .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_wr(load_wr), .load_done(load_done),
  .self_reset(self_reset), .port_power_down(port_power_down), .lt_err_evt(lt_err_evt),
  .pw_dest(pw_dest), .logical_transport_error_flag(logical_transport_error_flag),
  .boot_active(boot_active), .irq(irq)
);

// ===== dv/emrb_err_src.sv
`timescale 1ns/1ps
module emrb_err_src
  import emrb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              fire,
  input  wire logic [2:0]        port,
  input  wire emrb_word_t        info,
  output logic       [NPORT-1:0] lt_err_evt,
  output emrb_word_t [NPORT-1:0] lt_err_info
);
  logic [31:0] cnt = 32'h0;
  // info of idle ports changes every cycle so a stale capture shows up
  always @(posedge mclk) begin
    cnt <= cnt + 32'h1;
    lt_err_evt <= '0;
    lt_err_info <= {NPORT{~cnt}};
    if (fire) begin
      lt_err_evt[port] <= 1'b1;
      lt_err_info[port] <= info;
    end
  end
endmodule // emrb_err_src

// ===== dv/emrb_regs_test.sv
`timescale 1ns/1ps
module emrb_regs_test
  import emrb_pkg::*;
;
  logic mclk, rstn, reg_wr, reg_rd, load_wr, load_done, self_reset, fire, boot_active, irq;
  logic [15:0] reg_addr, load_addr, a;
  logic [31:0] reg_wdata, reg_rdata, load_wdata, d, ev_info, pwlast;
  logic [7:0]  port_power_down, evt, flag;
  logic [2:0]  ev_port;
  emrb_word_t [NPORT-1:0] info;
  emrb_pw_dest_s pw_dest;
  int fails, total_checks;

  emrb_regs i_emrb_regs (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .load_wr(load_wr), .load_addr(load_addr), .load_wdata(load_wdata),
    .load_done(load_done), .self_reset(self_reset), .port_power_down(port_power_down),
    .lt_err_evt(evt), .lt_err_info(info), .pw_dest(pw_dest),
    .logical_transport_error_flag(flag), .boot_active(boot_active), .irq(irq));
  emrb_err_src i_emrb_err_src (.mclk(mclk), .fire(fire), .port(ev_port), .info(ev_info),
    .lt_err_evt(evt), .lt_err_info(info));

  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic ld(input logic [15:0] ad, input logic [31:0] dt);
    @(posedge mclk);
    load_wr <= 1'b1;
    load_addr <= ad;
    load_wdata <= dt;
    @(posedge mclk);
    load_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic fire_evt(input logic [2:0] p, input logic [31:0] inf);
    @(posedge mclk);
    fire <= 1'b1;
    ev_port <= p;
    ev_info <= inf;
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  function automatic logic [31:0] exp_pw(input logic [31:0] v);
    return {15'h0, (v[15] ? v[31:16] : {8'h00, v[23:16]}), v[15]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    stop_test();
  end

  initial begin
    {rstn, reg_wr, reg_rd, load_wr, load_done, self_reset, fire} = '0;
    {reg_addr, load_addr, reg_wdata, load_wdata, ev_info, ev_port, port_power_down} = '0;
    void'($urandom(19941));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rd(HDR_OFS, 32'h0000_0007);
    rd(PWID_OFS, 32'h0000_0000);
    rd(16'h1004, 32'h0000_0000);
    rd(16'h1001, 32'h0000_0000);
    wr(HDR_OFS, 32'hFFFF_FFFF);
    wr(16'h1030, 32'hFFFF_FFFF);
    rd(HDR_OFS, 32'h0000_0007);
    rd(16'h1030, 32'h0000_0000);
    rd(PWID_OFS, 32'h0000_0000);
    ld(PWID_OFS, 32'hA5C3_8000);
    rd(PWID_OFS, 32'hA5C3_8000);
    @(posedge mclk);
    load_done <= 1'b1;
    @(posedge mclk);
    load_done <= 1'b0;
    #1 chk({31'h0, boot_active}, 32'h0);
    ld(PWID_OFS, 32'h0000_0000);
    rd(PWID_OFS, 32'hA5C3_8000);
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'h00FF_7FFF : (i == 1) ? 32'hFFFF_FFFF : $urandom;
      pwlast = d;
      wr(PWID_OFS, d);
      rd(PWID_OFS, d & 32'hFFFF_8000);
      chk({15'h0, pw_dest}, exp_pw(d));
    end
    wr(IRQ_EN_OFS, 32'h0000_00FF);
    for (int i = 0; i < 8; i++) begin
      a = WIN_BASE + 16'(i * 64);
      d = $urandom;
      fire_evt(3'(i), d);
      chk({24'h0, flag}, 32'h1 << i);
      chk({31'h0, irq}, 32'h1);
      rd(a, 32'h8000_0000);
      fire_evt(3'(i), ~d);
      rd(a + 16'h0008, d);
      rd(IRQ_STAT_OFS, 32'h1 << i);
      wr(IRQ_CLR_OFS, 32'h1 << i);
      chk({31'h0, irq}, 32'h0);
      // writing zero to the detect word clears the flag
      wr(a, 32'h0000_0000);
      chk({24'h0, flag}, 32'h0);
    end
    wr(IRQ_EN_OFS, 32'h0000_00DF);
    fire_evt(3'd5, 32'h1357_9BDF);
    chk({31'h0, irq}, 32'h0);
    rd(IRQ_STAT_OFS, 32'h0000_0020);
    wr(WIN_BASE + 16'h0140, 32'h8000_0000);
    chk({24'h0, flag}, 32'h0000_0020);
    @(posedge mclk);
    port_power_down <= 8'hFF;
    repeat (4) @(posedge mclk);
    rd(WIN_BASE + 16'h0140, 32'h0000_0000);
    wr(WIN_BASE + 16'h0140, 32'h0000_0000);
    fire_evt(3'd3, 32'h1234_5678);
    chk({24'h0, flag}, 32'h0);
    rd(PWID_OFS, pwlast & 32'hFFFF_8000);
    @(posedge mclk);
    port_power_down <= 8'h00;
    repeat (4) @(posedge mclk);
    rd(WIN_BASE + 16'h0140, 32'h0000_0000);
    rd(WIN_BASE + 16'h0148, 32'h0000_0000);
    fire_evt(3'd1, 32'h0F0F_0F0F);
    chk({31'h0, irq}, 32'h1);
    @(posedge mclk);
    self_reset <= 1'b1;
    @(posedge mclk);
    self_reset <= 1'b0;
    #1 chk({31'h0, boot_active}, 32'h1);
    chk({24'h0, flag}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(PWID_OFS, 32'h0000_0000);
    rd(IRQ_EN_OFS, 32'h0000_0000);
    stop_test();
  end
endmodule // emrb_regs_test
